// file: common/fes_pkg.sv
// constants shared by the erase/suspend sequencer of the serial nor flash core
// assumes a 200 mhz core clock and a 24-bit (3-byte) array address
package fes_pkg;
   // ********************************
   // opcodes
   // ********************************
   localparam logic [7:0] OP_SUBSECTOR_ERASE_A = 8'h52;
   localparam logic [7:0] OP_SUBSECTOR_ERASE_B = 8'h20;
   localparam logic [7:0] OP_SECTOR_ERASE      = 8'hd8;
   localparam logic [7:0] OP_BULK_ERASE_A      = 8'hc7;
   localparam logic [7:0] OP_BULK_ERASE_B      = 8'h60;
   localparam logic [7:0] OP_SUSPEND           = 8'h75;
   localparam logic [7:0] OP_RESUME            = 8'h7a;
   localparam logic [7:0] OP_CLEAR_FLAGS       = 8'h50;
   localparam logic [7:0] OP_WRITE_ENABLE      = 8'h06;
   localparam logic [7:0] OP_WRITE_DISABLE     = 8'h04;
   localparam logic [7:0] OP_PAGE_PROGRAM      = 8'h02;
   // ********************************
   // flag status layout
   // ********************************
   localparam int          FSR_READY      = 7;
   localparam int          FSR_ERASE_SUSP = 6;
   localparam int          FSR_ERASE_ERR  = 5;
   localparam int          FSR_PROG_ERR   = 4;
   localparam int          FSR_PROG_SUSP  = 2;
   localparam int          FSR_PROT_ERR   = 1;
   localparam logic [7:0]  FSR_RESET      = 8'h80;
   // ********************************
   // address and frame layout
   // ********************************
   localparam int          ADDR_W         = 24;
   localparam int          BITS_W         = 12;
   localparam logic [23:0] SUBSECTOR_MASK = 24'hfff000;
   localparam logic [23:0] SECTOR_MASK    = 24'hff0000;
   localparam logic [23:0] PAGE_MASK      = 24'hffff00;
   localparam logic [11:0] CMD_BITS       = 12'h008;
   localparam logic [11:0] ERASE_BITS     = 12'h020;
   localparam logic [11:0] PROG_MIN_BITS  = 12'h028;
   localparam logic [11:0] BITS_MAX       = 12'hfff;
   // ********************************
   // timing
   // ********************************
   localparam int CLK_MHZ                 = 200;
   localparam int SUBSECTOR_ERASE_TIME_US = 400;
   localparam int SECTOR_ERASE_TIME_US    = 1000;
   localparam int BULK_ERASE_TIME_US      = 200000;
   localparam int PAGE_PROGRAM_TIME_US    = 1000;
   localparam int SUSPEND_LATENCY_US      = 30;
   // ********************************
   // sequencer states
   // ********************************
   typedef enum logic [2:0] {
      ST_IDLE, ST_CHECK, ST_ERASE, ST_PROGRAM, ST_SUSPENDING
   } fes_state_type;
endpackage : fes_pkg

// file: core/fes_erase_sequencer.sv
// erase, page program completion and suspend/resume sequencer of a serial nor flash
// assumes protection and timeout answers come from logic on ref_clk, the link on link_sclk
//
// Overview of operation
// - erase only drives array bits to 1; erased region reads all ones
// - erase needs the write enable latch set; otherwise ignored silently
// - chip select off a byte boundary: nothing executes, no error, latch kept
// - erase runs self-timed for subsector, sector or bulk time by opcode
// - erase of a protected subsector refused; latch kept; flags 1 and 5 set
// - during erase controller bit reads 0, busy 1; reversed on completion
// - erase end clears the write enable latch, success or not
// - erase timeout clears the latch and sets the erase error flag
// - decoder takes two subsector, one sector and two bulk erase opcodes
// - any address inside a region selects it; bits sampled on rising clock
// - bulk erase refused if any sector locked; latch kept; flags 1 and 5
// - suspend opcode suspends program (flag 2) or erase (flag 6)
// - flag 7 rises after suspend latency; host waits to read it as 1
// - too little time left: operation finishes, suspend flag cleared
// - suspend state is volatile; flag status comes up as 80h
// - one nesting level: erase then program; resumes go program then erase
// - reads allowed except the suspended page or sector, whose data is undefined
// - program into erase-suspended sector ignored, sets flag 4, latch unchanged
// - resumed erase does not recheck lock bits changed while suspended
// - resume sets busy and clears controller bit; ignored when nothing suspended
// - page program runs self-timed for page program time after valid frame end
// - clear-flags opcode resets erase, program and protection error flags
`timescale 1ns/100ps
module fes_erase_sequencer #(
   parameter int SUBSECTOR_ERASE_CYC = fes_pkg::SUBSECTOR_ERASE_TIME_US * fes_pkg::CLK_MHZ,
   parameter int SECTOR_ERASE_CYC    = fes_pkg::SECTOR_ERASE_TIME_US * fes_pkg::CLK_MHZ,
   parameter int BULK_ERASE_CYC      = fes_pkg::BULK_ERASE_TIME_US * fes_pkg::CLK_MHZ,
   parameter int PAGE_PROGRAM_CYC    = fes_pkg::PAGE_PROGRAM_TIME_US * fes_pkg::CLK_MHZ,
   parameter int SUSPEND_LATENCY_CYC = fes_pkg::SUSPEND_LATENCY_US * fes_pkg::CLK_MHZ
) (
   // core clock and reset
   input  wire logic        ref_clk,
   input  wire logic        rstn,
   // serial link
   input  wire logic        link_sclk,
   input  wire logic        link_cs_n,
   input  wire logic [3:0]  serial_io_lines_in,
   output logic      [3:0]  serial_io_lines_out,
   output logic      [3:0]  serial_io_lines_oe,
   // protection and array answers
   input  wire logic        region_locked,
   input  wire logic        any_sector_locked,
   input  wire logic        op_timeout,
   // status
   output logic             wip,
   output logic             wel,
   output logic      [7:0]  flag_status,
   // array control
   output logic             erase_busy,
   output logic             program_busy,
   output logic      [23:0] op_addr,
   output logic      [23:0] prog_susp_addr,
   output logic      [23:0] erase_susp_addr
);
   // ********************************
   // reset release
   // ********************************
   logic rst_meta;
   logic rst_n_sync;

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         rst_meta   <= 1'b0;
         rst_n_sync <= 1'b0;
      end else begin
         rst_meta   <= 1'b1;
         rst_n_sync <= rst_meta;
      end
   end

   // ********************************
   // link side, clocked by link_sclk
   // ********************************
   // frame contents stay put after chip select rises because updates only run while link_cs_n is low
   logic        in_frame;
   logic [11:0] lk_bits;
   logic [31:0] lk_shift;

   always_ff @(posedge link_sclk or posedge link_cs_n) begin
      if (link_cs_n) in_frame <= 1'b0;
      else           in_frame <= 1'b1;
   end

   always_ff @(posedge link_sclk or negedge rst_n_sync) begin
      if (!rst_n_sync) begin
         lk_bits  <= '0;
         lk_shift <= '0;
      end else if (!link_cs_n) begin
         if (!in_frame) begin
            lk_bits  <= 12'h001;
            lk_shift <= {31'h0, serial_io_lines_in[0]};
         end else begin
            if (lk_bits != fes_pkg::BITS_MAX) lk_bits <= lk_bits + 12'h001;
            if (lk_bits < fes_pkg::ERASE_BITS)
               lk_shift <= {lk_shift[30:0], serial_io_lines_in[0]};
         end
      end
   end

   // ********************************
   // chip select crossing
   // ********************************
   logic cs_meta;
   logic cs_sync;
   logic cs_prev;

   always_ff @(posedge ref_clk or negedge rst_n_sync) begin
      if (!rst_n_sync) begin
         cs_meta <= 1'b1;
         cs_sync <= 1'b1;
         cs_prev <= 1'b1;
      end else begin
         cs_meta <= link_cs_n;
         cs_sync <= cs_meta;
         cs_prev <= cs_sync;
      end
   end

   // ********************************
   // decode
   // ********************************
   wire        frame_end = cs_sync & ~cs_prev & (lk_bits != '0);
   wire [7:0]  cmd_op    = (lk_bits < fes_pkg::ERASE_BITS) ? lk_shift[7:0] : lk_shift[31:24];
   wire [23:0] cmd_addr  = lk_shift[23:0];
   wire        byte_ok   = (lk_bits[2:0] == 3'h0);
   wire        len_cmd   = (lk_bits == fes_pkg::CMD_BITS);
   wire        len_erase = (lk_bits == fes_pkg::ERASE_BITS);
   wire        len_prog  = byte_ok & (lk_bits >= fes_pkg::PROG_MIN_BITS);
   wire        is_sub    = (cmd_op == fes_pkg::OP_SUBSECTOR_ERASE_A) |
                           (cmd_op == fes_pkg::OP_SUBSECTOR_ERASE_B);
   wire        is_sec    = (cmd_op == fes_pkg::OP_SECTOR_ERASE);
   wire        is_bulk   = (cmd_op == fes_pkg::OP_BULK_ERASE_A) |
                           (cmd_op == fes_pkg::OP_BULK_ERASE_B);
   wire        do_erase  = frame_end & (((is_sub | is_sec) & len_erase) | (is_bulk & len_cmd));
   wire        do_prog   = frame_end & len_prog & (cmd_op == fes_pkg::OP_PAGE_PROGRAM);
   wire        do_wren   = frame_end & len_cmd & (cmd_op == fes_pkg::OP_WRITE_ENABLE);
   wire        do_wrdi   = frame_end & len_cmd & (cmd_op == fes_pkg::OP_WRITE_DISABLE);
   wire        do_susp   = frame_end & len_cmd & (cmd_op == fes_pkg::OP_SUSPEND);
   wire        do_resume = frame_end & len_cmd & (cmd_op == fes_pkg::OP_RESUME);
   wire        do_clear  = frame_end & len_cmd & (cmd_op == fes_pkg::OP_CLEAR_FLAGS);
   wire [23:0] erase_mask = is_sub ? fes_pkg::SUBSECTOR_MASK : fes_pkg::SECTOR_MASK;
   wire [31:0] erase_cyc  = is_bulk ? 32'(BULK_ERASE_CYC) :
                            is_sec  ? 32'(SECTOR_ERASE_CYC) : 32'(SUBSECTOR_ERASE_CYC);

   // ********************************
   // sequencer state
   // ********************************
   fes_pkg::fes_state_type state;
   fes_pkg::fes_state_type next_state;
   logic [31:0] time_left;
   logic [31:0] next_time_left;
   logic [31:0] lat_left;
   logic [31:0] next_lat_left;
   logic [31:0] er_left;
   logic [31:0] next_er_left;
   logic [31:0] pg_left;
   logic [31:0] next_pg_left;
   logic [31:0] pend_cyc;
   logic [31:0] next_pend_cyc;
   logic        pend_erase;
   logic        next_pend_erase;
   logic        pend_bulk;
   logic        next_pend_bulk;
   logic        susp_erase;
   logic        next_susp_erase;
   logic        next_wip;
   logic        next_wel;
   logic [7:0]  next_fsr;
   logic [23:0] next_op_addr;
   logic [23:0] next_pg_addr;
   logic [23:0] next_er_addr;

   wire run_done  = (time_left == 32'h1);
   wire can_susp  = (time_left > 32'(SUSPEND_LATENCY_CYC) + 32'h1);
   wire same_sect = ((op_addr & fes_pkg::SECTOR_MASK) == erase_susp_addr);
   wire erase_s   = flag_status[fes_pkg::FSR_ERASE_SUSP];
   wire prog_s    = flag_status[fes_pkg::FSR_PROG_SUSP];

   always_comb begin
      next_state      = state;
      next_time_left  = time_left;
      next_lat_left   = lat_left;
      next_er_left    = er_left;
      next_pg_left    = pg_left;
      next_pend_cyc   = pend_cyc;
      next_pend_erase = pend_erase;
      next_pend_bulk  = pend_bulk;
      next_susp_erase = susp_erase;
      next_wip        = wip;
      next_wel        = wel;
      next_fsr        = flag_status;
      next_op_addr    = op_addr;
      next_pg_addr    = prog_susp_addr;
      next_er_addr    = erase_susp_addr;
      if (time_left != '0) next_time_left = time_left - 32'h1;
      if (do_clear) begin
         next_fsr[fes_pkg::FSR_ERASE_ERR] = 1'b0;
         next_fsr[fes_pkg::FSR_PROG_ERR]  = 1'b0;
         next_fsr[fes_pkg::FSR_PROT_ERR]  = 1'b0;
      end
      case (state)
         fes_pkg::ST_IDLE: begin
            if (do_wren) next_wel = 1'b1;
            if (do_wrdi) next_wel = 1'b0;
            // erase and program wait for the lock answer to the latched address
            if (do_erase && wel && !erase_s && !prog_s) begin
               next_state      = fes_pkg::ST_CHECK;
               next_pend_erase = 1'b1;
               next_pend_bulk  = is_bulk;
               next_pend_cyc   = erase_cyc;
               next_op_addr    = is_bulk ? '0 : (cmd_addr & erase_mask);
            end else if (do_prog && wel && !prog_s) begin
               next_state      = fes_pkg::ST_CHECK;
               next_pend_erase = 1'b0;
               next_pend_bulk  = 1'b0;
               next_pend_cyc   = 32'(PAGE_PROGRAM_CYC);
               next_op_addr    = cmd_addr;
            end else if (do_resume && prog_s) begin
               next_state                        = fes_pkg::ST_PROGRAM;
               next_time_left                    = pg_left;
               next_op_addr                      = prog_susp_addr;
               next_fsr[fes_pkg::FSR_PROG_SUSP]  = 1'b0;
               next_fsr[fes_pkg::FSR_READY]      = 1'b0;
               next_wip                          = 1'b1;
            end else if (do_resume && erase_s) begin
               next_state                        = fes_pkg::ST_ERASE;
               next_time_left                    = er_left;
               next_op_addr                      = erase_susp_addr;
               next_fsr[fes_pkg::FSR_ERASE_SUSP] = 1'b0;
               next_fsr[fes_pkg::FSR_READY]      = 1'b0;
               next_wip                          = 1'b1;
            end
         end
         fes_pkg::ST_CHECK: begin
            next_state = fes_pkg::ST_IDLE;
            if (pend_erase && (pend_bulk ? any_sector_locked : region_locked)) begin
               next_fsr[fes_pkg::FSR_PROT_ERR]  = 1'b1;
               next_fsr[fes_pkg::FSR_ERASE_ERR] = 1'b1;
            end else if (!pend_erase && erase_s && same_sect) begin
               next_fsr[fes_pkg::FSR_PROG_ERR]  = 1'b1;
            end else if (!pend_erase && region_locked) begin
               next_fsr[fes_pkg::FSR_PROT_ERR]  = 1'b1;
               next_fsr[fes_pkg::FSR_PROG_ERR]  = 1'b1;
            end else begin
               next_state                   = pend_erase ? fes_pkg::ST_ERASE : fes_pkg::ST_PROGRAM;
               next_time_left               = pend_cyc;
               next_wip                     = 1'b1;
               next_fsr[fes_pkg::FSR_READY] = 1'b0;
            end
         end
         fes_pkg::ST_ERASE, fes_pkg::ST_PROGRAM: begin
            if (run_done || op_timeout) begin
               next_state                   = fes_pkg::ST_IDLE;
               next_time_left               = '0;
               next_wip                     = 1'b0;
               next_wel                     = 1'b0;
               next_fsr[fes_pkg::FSR_READY] = 1'b1;
               if (state == fes_pkg::ST_ERASE) begin
                  next_fsr[fes_pkg::FSR_ERASE_SUSP] = 1'b0;
                  if (op_timeout) next_fsr[fes_pkg::FSR_ERASE_ERR] = 1'b1;
               end else begin
                  next_fsr[fes_pkg::FSR_PROG_SUSP] = 1'b0;
                  if (op_timeout) next_fsr[fes_pkg::FSR_PROG_ERR] = 1'b1;
               end
            end else if (do_susp && can_susp) begin
               next_state      = fes_pkg::ST_SUSPENDING;
               next_lat_left   = 32'(SUSPEND_LATENCY_CYC);
               next_susp_erase = (state == fes_pkg::ST_ERASE);
               if (state == fes_pkg::ST_ERASE) next_fsr[fes_pkg::FSR_ERASE_SUSP] = 1'b1;
               else                            next_fsr[fes_pkg::FSR_PROG_SUSP]  = 1'b1;
            end
         end
         fes_pkg::ST_SUSPENDING: begin
            // the operation keeps running through the latency, so the saved count is exact
            next_lat_left = lat_left - 32'h1;
            if (lat_left == 32'h1) begin
               next_state                   = fes_pkg::ST_IDLE;
               next_time_left               = '0;
               next_wip                     = 1'b0;
               next_fsr[fes_pkg::FSR_READY] = 1'b1;
               if (susp_erase) begin
                  next_er_left = time_left - 32'h1;
                  next_er_addr = op_addr & fes_pkg::SECTOR_MASK;
               end else begin
                  next_pg_left = time_left - 32'h1;
                  next_pg_addr = op_addr & fes_pkg::PAGE_MASK;
               end
            end
         end
         default: begin
            next_state = fes_pkg::ST_IDLE;
         end
      endcase
   end

   // ********************************
   // registers
   // ********************************
   always_ff @(posedge ref_clk or negedge rst_n_sync) begin
      if (!rst_n_sync) begin
         state      <= fes_pkg::ST_IDLE;
         time_left  <= '0;
         lat_left   <= '0;
         er_left    <= '0;
         pg_left    <= '0;
         pend_cyc   <= '0;
         pend_erase <= 1'b0;
         pend_bulk  <= 1'b0;
         susp_erase <= 1'b0;
      end else begin
         state      <= next_state;
         time_left  <= next_time_left;
         lat_left   <= next_lat_left;
         er_left    <= next_er_left;
         pg_left    <= next_pg_left;
         pend_cyc   <= next_pend_cyc;
         pend_erase <= next_pend_erase;
         pend_bulk  <= next_pend_bulk;
         susp_erase <= next_susp_erase;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n_sync) begin
      if (!rst_n_sync) begin
         wip             <= 1'b0;
         wel             <= 1'b0;
         flag_status     <= fes_pkg::FSR_RESET;
         op_addr         <= '0;
         prog_susp_addr  <= '0;
         erase_susp_addr <= '0;
      end else begin
         wip             <= next_wip;
         wel             <= next_wel;
         flag_status     <= next_fsr;
         op_addr         <= next_op_addr;
         prog_susp_addr  <= next_pg_addr;
         erase_susp_addr <= next_er_addr;
      end
   end

   // array engine drives ones only while erase_busy, so erase never clears a bit
   always_ff @(posedge ref_clk or negedge rst_n_sync) begin
      if (!rst_n_sync) begin
         erase_busy          <= 1'b0;
         program_busy        <= 1'b0;
         serial_io_lines_out <= '0;
         serial_io_lines_oe  <= '0;
      end else begin
         erase_busy          <= (next_state == fes_pkg::ST_ERASE) |
                                ((next_state == fes_pkg::ST_SUSPENDING) & next_susp_erase);
         program_busy        <= (next_state == fes_pkg::ST_PROGRAM) |
                                ((next_state == fes_pkg::ST_SUSPENDING) & ~next_susp_erase);
         serial_io_lines_out <= '0;
         serial_io_lines_oe  <= '0;
      end
   end
endmodule : fes_erase_sequencer

// file: testbench/fes_erase_sequencer_assertions.sv
// concurrent checks on the ports of the erase/suspend sequencer
// assumes binding into fes_erase_sequencer; checks disabled while rstn is low
`timescale 1ns/100ps
module fes_erase_sequencer_assertions #(
   parameter int SUSPEND_LATENCY_CYC = 20
) (
   // clock and reset
   input wire logic       ref_clk,
   input wire logic       rstn,
   // watched outputs
   input wire logic       wip,
   input wire logic       wel,
   input wire logic       erase_busy,
   input wire logic       program_busy,
   input wire logic [7:0] flag_status,
   input wire logic [3:0] serial_io_lines_oe
);
   // ********************************
   // properties
   // ********************************
   localparam int LAT_HI = SUSPEND_LATENCY_CYC + 5;
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rstn);
   sequence s_still_busy;
      (!flag_status[7]) [*8];
   endsequence
   sequence s_ready;
      ##[1:LAT_HI] flag_status[7];
   endsequence
   property p_ready_busy;
      flag_status[7] == !wip;
   endproperty
   property p_busy_wip;
      (erase_busy || program_busy) |-> wip;
   endproperty
   property p_one_active;
      !(erase_busy && program_busy);
   endproperty
   property p_end_wel;
      $fell(erase_busy) && !flag_status[6] |-> ##[0:2] !wel;
   endproperty
   property p_prot;
      $rose(flag_status[1]) |-> wel && !wip;
   endproperty
   property p_susp;
      $rose(flag_status[6]) |-> s_still_busy ##0 s_ready;
   endproperty
   property p_resume;
      $fell(flag_status[6]) |-> wip && !flag_status[7];
   endproperty
   property p_timeout;
      $rose(flag_status[5]) |-> ##[0:2] (!erase_busy && !flag_status[6]);
   endproperty
   property p_fixed;
      flag_status[3] == 1'b0 && flag_status[0] == 1'b0 && serial_io_lines_oe == 4'h0;
   endproperty
   a_ready_busy: assert property (p_ready_busy) else $error("ready bit not inverse of wip");
   a_busy_wip: assert property (p_busy_wip) else $error("busy without wip");
   a_one_active: assert property (p_one_active) else $error("erase and program both run");
   a_end_wel: assert property (p_end_wel) else $error("wel kept after erase end");
   a_prot: assert property (p_prot) else $error("protection error with wel clear");
   a_susp: assert property (p_susp) else $error("suspend latency wrong");
   a_resume: assert property (p_resume) else $error("resume did not restart");
   a_timeout: assert property (p_timeout) else $error("erase error without stop");
   a_fixed: assert property (p_fixed) else $error("unused bits or enables set");
endmodule : fes_erase_sequencer_assertions
bind fes_erase_sequencer fes_erase_sequencer_assertions #(
   .SUSPEND_LATENCY_CYC(SUSPEND_LATENCY_CYC)
) u_chk (.ref_clk(ref_clk), .rstn(rstn), .wip(wip), .wel(wel), .erase_busy(erase_busy),
   .program_busy(program_busy), .flag_status(flag_status),
   .serial_io_lines_oe(serial_io_lines_oe));

// file: testbench/fes_host_model.sv
// host controller model: frames bits msb first on line 0 at a 125 ns link clock
// assumes the bench leaves idle time between frames
`timescale 1ns/100ps
module fes_host_model (
   // link
   output logic       link_sclk,
   output logic       link_cs_n,
   output logic [3:0] serial_io_lines_in
);
   initial begin
      link_sclk = 1'b0;
      link_cs_n = 1'b1;
      serial_io_lines_in = 4'ha;
   end
   // clock stands still outside frames; the idle line shows the inverse value
   task automatic send(input logic [39:0] d, input int n);
      // small skew keeps link edges off the core clock edges
      #1.3;
      link_cs_n = 1'b0;
      for (int i = n - 1; i >= 0; i--) begin
         serial_io_lines_in = {3'h5, d[i]};
         #62.5 link_sclk = 1'b1;
         #62.5 link_sclk = 1'b0;
      end
      #62.5 link_cs_n = 1'b1;
      serial_io_lines_in = ~serial_io_lines_in;
   endtask : send
endmodule : fes_host_model

// file: testbench/test_flash_erase_suspend_sequencer.sv
// bench for the erase/suspend sequencer with shortened operation times
// assumes the host model drives the link and the bench the lock and timeout answers
`timescale 1ns/100ps
module test_flash_erase_suspend_sequencer;
   localparam int SS = 2000, SE = 3000, BE = 4000;
   logic ref_clk = 1'b0, rstn = 1'b0, region_locked = 1'b0, any_sector_locked = 1'b0;
   logic op_timeout = 1'b0, wip, wel, erase_busy, program_busy, link_sclk, link_cs_n;
   logic [3:0] dq_in, dq_out, dq_oe;
   logic [7:0] flag_status;
   logic [23:0] op_addr, prog_susp_addr, erase_susp_addr;
   int bad_count = 0, n_checks = 0, cycles = 0;
   always #2.5 ref_clk = ~ref_clk;
   fes_host_model host (.link_sclk(link_sclk), .link_cs_n(link_cs_n), .serial_io_lines_in(dq_in));
   fes_erase_sequencer #(.SUBSECTOR_ERASE_CYC(SS), .SECTOR_ERASE_CYC(SE), .BULK_ERASE_CYC(BE),
      .PAGE_PROGRAM_CYC(2000), .SUSPEND_LATENCY_CYC(20)) DUT (.ref_clk(ref_clk), .rstn(rstn),
      .link_sclk(link_sclk), .link_cs_n(link_cs_n), .serial_io_lines_in(dq_in),
      .serial_io_lines_out(dq_out), .serial_io_lines_oe(dq_oe), .region_locked(region_locked),
      .any_sector_locked(any_sector_locked), .op_timeout(op_timeout), .wip(wip), .wel(wel),
      .flag_status(flag_status), .erase_busy(erase_busy), .program_busy(program_busy),
      .op_addr(op_addr), .prog_susp_addr(prog_susp_addr), .erase_susp_addr(erase_susp_addr));
   // ********************************
   // helpers
   // ********************************
   task automatic end_sim;
      $display("checks %0d mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask : end_sim
   task automatic chk(input string s, input logic [23:0] seen, input logic [23:0] exp);
      n_checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("ERROR %s expected %h seen %h", s, exp, seen);
      end
   endtask : chk
   task automatic cmd(input logic [39:0] d, input int n);
      host.send(d, n);
      repeat (12) @(negedge ref_clk);
   endtask : cmd
   // bounded wait: 0 wip, 1 ready bit
   task automatic wait_on(input int sel, input logic v);
      int k;
      k = 0;
      while (k < 6000 && (sel == 0 ? wip : flag_status[7]) !== v) begin
         @(negedge ref_clk);
         k++;
      end
      chk("wait", k < 6000, 24'h1);
   endtask : wait_on
   // ********************************
   // scenarios
   // ********************************
   task automatic t_erase;
      logic [7:0] op [5] = '{8'h52, 8'h20, 8'hd8, 8'hc7, 8'h60};
      int cyc [5] = '{SS, SS, SE, BE, BE};
      logic [23:0] msk [3] = '{fes_pkg::SUBSECTOR_MASK, fes_pkg::SUBSECTOR_MASK,
         fes_pkg::SECTOR_MASK};
      int k;
      for (int i = 0; i < 5; i++) begin
         cmd(40'h06, 8);
         if (i < 3) host.send({op[i], 24'h123456}, 32);
         else host.send(op[i], 8);
         repeat (8) @(negedge ref_clk);
         chk("op_addr", op_addr, i < 3 ? 24'h123456 & msk[i] : 24'h0);
         k = 0;
         while (wip === 1'b1 && k < 9000) begin
            @(negedge ref_clk);
            k++;
         end
         chk("erase_len", k + 8 >= cyc[i] && k <= cyc[i], 24'h1);
         chk("wel_end", wel, 24'h0);
         chk("fsr_end", flag_status, 24'h80);
      end
      $display("test erase done");
   endtask : t_erase
   task automatic t_refuse;
      cmd({8'h20, 24'h001000}, 32);
      chk("no_wel", {wip, wel, flag_status}, 24'h080);
      cmd(40'h06, 8);
      cmd({8'h52, 24'h001000}, 31);
      chk("bad_len", {wip, wel, flag_status}, 24'h180);
      region_locked = 1'b1;
      cmd({8'hd8, 24'h001000}, 32);
      chk("locked", {wip, wel, flag_status}, 24'h1a2);
      region_locked = 1'b0;
      cmd(40'h50, 8);
      chk("clear", flag_status, 24'h80);
      any_sector_locked = 1'b1;
      cmd(40'hc7, 8);
      chk("bulk_lock", {wel, flag_status}, 24'h1a2);
      any_sector_locked = 1'b0;
      cmd(40'h50, 8);
      cmd({8'h20, 24'h002000}, 32);
      op_timeout = 1'b1;
      @(negedge ref_clk) op_timeout = 1'b0;
      repeat (4) @(negedge ref_clk);
      chk("timeout", {wip, wel, flag_status}, 24'h0a0);
      cmd(40'h50, 8);
      $display("test refuse done");
   endtask : t_refuse
   task automatic t_suspend;
      cmd(40'h75, 8);
      chk("idle_susp", flag_status, 24'h80);
      cmd(40'h7a, 8);
      chk("idle_res", wip, 24'h0);
      cmd(40'h06, 8);
      cmd({8'hd8, 24'h054321}, 32);
      cmd(40'h75, 8);
      chk("esusp", flag_status[6], 24'h1);
      wait_on(1, 1'b1);
      chk("esusp_wip", wip, 24'h0);
      chk("esusp_addr", erase_susp_addr, 24'h050000);
      cmd(40'h06, 8);
      cmd({8'h02, 24'h050100, 8'h00}, 40);
      chk("prog_in_susp", {wel, flag_status}, 24'h1d0);
      cmd(40'h50, 8);
      cmd({8'h02, 24'h200010, 8'h00}, 40);
      cmd(40'h75, 8);
      chk("psusp", flag_status[2], 24'h1);
      wait_on(1, 1'b1);
      chk("psusp_addr", prog_susp_addr, 24'h200000);
      cmd(40'h7a, 8);
      chk("res_prog", {program_busy, erase_busy, flag_status}, 24'h240);
      wait_on(0, 1'b0);
      chk("prog_done", flag_status, 24'hc0);
      region_locked = 1'b1;
      cmd(40'h7a, 8);
      chk("res_erase", {erase_busy, wip, flag_status[7]}, 24'h6);
      wait_on(0, 1'b0);
      region_locked = 1'b0;
      chk("erase_done", {wel, flag_status}, 24'h080);
      $display("test suspend done");
   endtask : t_suspend
   // ********************************
   // sequence and watchdog
   // ********************************
   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == 80000) begin
         bad_count++;
         end_sim();
      end
   end
   initial begin
      repeat (10) @(negedge ref_clk);
      chk("reset", {dq_out, dq_oe, wip, wel, flag_status}, 24'h00080);
      rstn = 1'b1;
      repeat (6) @(negedge ref_clk);
      t_erase();
      t_refuse();
      t_suspend();
      end_sim();
   end
endmodule : test_flash_erase_suspend_sequencer
